// ==== rtl/reset_bit_store.sv ====
// Storage flops of the soft reset control word.
// Assumes a synchronised active-low reset and masks from the front end.
`timescale 1ns/1ps
module reset_bit_store (
  input wire logic clk,
  input wire logic rst_n,
  reset_store_if.store st
);

  logic [soft_reset_pkg::DATA_W-1:0] value_reg;
  logic [soft_reset_pkg::DATA_W-1:0] value_next;

  // Masked merge, then clear any position not allowed
  always_comb begin
    value_next = value_reg;
    if (st.wr_en) begin
      value_next = (value_reg & ~st.wr_mask) | (st.wr_data & st.wr_mask);
    end
    value_next = value_next & st.allow_mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= soft_reset_pkg::SOFT_RESET_RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign st.value = value_reg;

endmodule : reset_bit_store

// ==== rtl/reset_store_if.sv ====
// Carrier between the bus front end and the reset bit store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface reset_store_if;
  logic wr_en;
  logic [soft_reset_pkg::DATA_W-1:0] wr_data;
  logic [soft_reset_pkg::DATA_W-1:0] wr_mask;
  logic [soft_reset_pkg::DATA_W-1:0] allow_mask;
  logic [soft_reset_pkg::DATA_W-1:0] value;

  modport front (
    output wr_en,
    output wr_data,
    output wr_mask,
    output allow_mask,
    input value
  );

  modport store (
    input wr_en,
    input wr_data,
    input wr_mask,
    input allow_mask,
    output value
  );
endinterface : reset_store_if

// ==== rtl/soft_reset_bank.sv ====
// Peripheral soft reset bank with a classic Wishbone slave port.
// Assumes capability_mask_2 comes from logic on clk; reset_n is asynchronous.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module soft_reset_bank (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [soft_reset_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [soft_reset_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [soft_reset_pkg::DATA_W-1:0] wb_dat_i,
  output logic [soft_reset_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [soft_reset_pkg::DATA_W-1:0] capability_mask_2,
  output logic analog_cmp_2_reset,
  output logic analog_cmp_1_reset,
  output logic analog_cmp_0_reset,
  output logic gp_counter_3_reset,
  output logic gp_counter_2_reset,
  output logic gp_counter_1_reset,
  output logic gp_counter_0_reset,
  output logic two_wire_unit_0_reset,
  output logic sync_serial_1_reset,
  output logic sync_serial_0_reset,
  output logic async_serial_2_reset,
  output logic async_serial_1_reset,
  output logic async_serial_0_reset
);

  // Byte lanes to bit mask
  function automatic logic [soft_reset_pkg::DATA_W-1:0] lane_mask(
    input logic [soft_reset_pkg::SEL_W-1:0] sel
  );
    logic [soft_reset_pkg::DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < soft_reset_pkg::SEL_W; i++) begin
      m[i*soft_reset_pkg::BYTE_W +: soft_reset_pkg::BYTE_W] = {soft_reset_pkg::BYTE_W{sel[i]}};
    end
    return m;
  endfunction : lane_mask

  // Word address match
  function automatic logic reg_hit(input logic [soft_reset_pkg::ADDR_W-1:0] adr);
    return adr[soft_reset_pkg::ADDR_W-1:soft_reset_pkg::WORD_LSB] ==
      soft_reset_pkg::SOFT_RESET_CONTROL_BANK_1_OFFSET[soft_reset_pkg::ADDR_W-1:
      soft_reset_pkg::WORD_LSB];
  endfunction : reg_hit

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  logic rst_n;
  assign rst_n = rst_n_reg;

  reset_store_if st ();

  reset_bit_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .st(st)
  );

  // Bus request decode
  logic req;
  logic hit;
  logic [soft_reset_pkg::DATA_W-1:0] allow;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit = reg_hit(wb_adr_i);
  assign allow = soft_reset_pkg::IMPLEMENTED_MASK & capability_mask_2;

  assign st.wr_en = req && wb_we_i && hit;
  assign st.wr_data = wb_dat_i;
  assign st.wr_mask = lane_mask(wb_sel_i) & allow;
  assign st.allow_mask = allow;

  // Acknowledge: one cycle after the request, for one cycle
  logic ack_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  assign wb_ack_o = ack_reg;

  // Read data captured with the acknowledge
  logic [soft_reset_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= soft_reset_pkg::UNMAPPED_READ_VALUE;
    end else if (req && !wb_we_i) begin
      if (hit) begin
        rdata_reg <= st.value & soft_reset_pkg::IMPLEMENTED_MASK;
      end else begin
        rdata_reg <= soft_reset_pkg::UNMAPPED_READ_VALUE;
      end
    end
  end

  assign wb_dat_o = rdata_reg;

  // Reset lines straight from the store flops
  assign analog_cmp_2_reset = st.value[soft_reset_pkg::ANALOG_CMP_2_BIT];
  assign analog_cmp_1_reset = st.value[soft_reset_pkg::ANALOG_CMP_1_BIT];
  assign analog_cmp_0_reset = st.value[soft_reset_pkg::ANALOG_CMP_0_BIT];
  assign gp_counter_3_reset = st.value[soft_reset_pkg::GP_COUNTER_3_BIT];
  assign gp_counter_2_reset = st.value[soft_reset_pkg::GP_COUNTER_2_BIT];
  assign gp_counter_1_reset = st.value[soft_reset_pkg::GP_COUNTER_1_BIT];
  assign gp_counter_0_reset = st.value[soft_reset_pkg::GP_COUNTER_0_BIT];
  assign two_wire_unit_0_reset = st.value[soft_reset_pkg::TWO_WIRE_0_BIT];
  assign sync_serial_1_reset = st.value[soft_reset_pkg::SYNC_SERIAL_1_BIT];
  assign sync_serial_0_reset = st.value[soft_reset_pkg::SYNC_SERIAL_0_BIT];
  assign async_serial_2_reset = st.value[soft_reset_pkg::ASYNC_SERIAL_2_BIT];
  assign async_serial_1_reset = st.value[soft_reset_pkg::ASYNC_SERIAL_1_BIT];
  assign async_serial_0_reset = st.value[soft_reset_pkg::ASYNC_SERIAL_0_BIT];

  // Checks
  logic wr_full;
  assign wr_full = req && wb_we_i && hit && (wb_sel_i == {soft_reset_pkg::SEL_W{1'b1}});

  AST_ACK_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  AST_ACK_NEXT: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
  ) else $error("request not acknowledged in the next cycle");

  AST_GATED_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.wr_en |=> ((st.value & ~$past(allow)) == 32'h0000_0000)
  ) else $error("write reached a position without capability");

  AST_FULL_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_full |=> (st.value == ($past(wb_dat_i) & $past(allow)))
  ) else $error("full write did not store masked data");

  AST_RESET_CLEAR: assert property (
    @(posedge clk)
    $rose(rst_n) |-> (st.value == soft_reset_pkg::SOFT_RESET_RESET_VALUE) && !wb_ack_o
  ) else $error("register not clear after reset");

  AST_READBACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    (req && !wb_we_i && hit) |=> wb_ack_o && (wb_dat_o == $past(st.value))
  ) else $error("read data differs from stored value");

  AST_COUNTER_SET: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st.wr_en && wb_sel_i[2] && allow[soft_reset_pkg::GP_COUNTER_0_BIT] &&
      wb_dat_i[soft_reset_pkg::GP_COUNTER_0_BIT]) |=> gp_counter_0_reset
  ) else $error("counter 0 reset not asserted after write");

  AST_TWO_WIRE_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st.wr_en && wb_sel_i[1] && !wb_dat_i[soft_reset_pkg::TWO_WIRE_0_BIT]) |=>
      !two_wire_unit_0_reset
  ) else $error("two-wire reset not released after clearing write");

  AST_SERIAL_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st.wr_en && allow[soft_reset_pkg::SYNC_SERIAL_1_BIT] && $stable(allow)) |=>
      $stable(sync_serial_1_reset)
  ) else $error("sync serial 1 reset changed without a write");

  AST_ASYNC_MAP: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wb_ack_o && $past(!wb_we_i && hit)) |->
      wb_dat_o[soft_reset_pkg::ASYNC_SERIAL_2_BIT] == $past(async_serial_2_reset)
  ) else $error("async serial 2 bit mismatch");

  AST_RESERVED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    wb_ack_o |-> ((wb_dat_o & ~soft_reset_pkg::IMPLEMENTED_MASK) == 32'h0000_0000)
  ) else $error("unused position read nonzero");

  AST_NO_CAP_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    !allow[soft_reset_pkg::ANALOG_CMP_2_BIT] |=> ##0 !analog_cmp_2_reset
  ) else $error("comparator 2 reset set without capability");

  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!rst_n)
    (req && !hit) |=> wb_ack_o && (st.value == ($past(st.value) & $past(allow))) &&
      ($past(wb_we_i) || (wb_dat_o == soft_reset_pkg::UNMAPPED_READ_VALUE))
  ) else $error("unmapped access had an effect");

endmodule : soft_reset_bank

// ==== rtl/soft_reset_pkg.sv ====
// Constants for the peripheral soft reset bank.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package soft_reset_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_LSB = 2;

  // Register offset and reset value
  localparam logic [ADDR_W-1:0] SOFT_RESET_CONTROL_BANK_1_OFFSET = 12'h044;
  localparam logic [DATA_W-1:0] SOFT_RESET_RESET_VALUE = 32'h0000_0000;

  // Field positions
  localparam int unsigned ANALOG_CMP_2_BIT = 26;
  localparam int unsigned ANALOG_CMP_1_BIT = 25;
  localparam int unsigned ANALOG_CMP_0_BIT = 24;
  localparam int unsigned GP_COUNTER_3_BIT = 19;
  localparam int unsigned GP_COUNTER_2_BIT = 18;
  localparam int unsigned GP_COUNTER_1_BIT = 17;
  localparam int unsigned GP_COUNTER_0_BIT = 16;
  localparam int unsigned TWO_WIRE_0_BIT = 12;
  localparam int unsigned SYNC_SERIAL_1_BIT = 5;
  localparam int unsigned SYNC_SERIAL_0_BIT = 4;
  localparam int unsigned ASYNC_SERIAL_2_BIT = 2;
  localparam int unsigned ASYNC_SERIAL_1_BIT = 1;
  localparam int unsigned ASYNC_SERIAL_0_BIT = 0;

  // Positions that hold storage; all others read zero
  localparam logic [DATA_W-1:0] IMPLEMENTED_MASK = 32'h070f_1037;

  // Value returned for an unmapped address
  localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

endpackage : soft_reset_pkg

// ==== tb/test_soft_reset_bank.sv ====
// Self-checking bench for the peripheral soft reset bank.
// Assumes the bank answers every Wishbone cycle with a one-cycle ack.
`timescale 1ns/1ps
module test_soft_reset_bank;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] capability_mask_2 = 32'hffff_ffff;
  logic a2, a1, a0, g3, g2, g1, g0, tw, s1, s0, u2, u1, u0;
  logic [31:0] outs;
  logic [31:0] rd;
  int errors = 0;
  int checked = 0;
  int pos [13] = '{26, 25, 24, 19, 18, 17, 16, 12, 5, 4, 2, 1, 0};
  localparam logic [31:0] IMPL = soft_reset_pkg::IMPLEMENTED_MASK;
  localparam logic [11:0] REG = soft_reset_pkg::SOFT_RESET_CONTROL_BANK_1_OFFSET;

  // Reset lines gathered at their register positions
  assign outs = {5'h00, a2, a1, a0, 4'h0, g3, g2, g1, g0, 3'h0, tw, 6'h00, s1, s0, 1'b0,
    u2, u1, u0};

  always #50 clk = ~clk;

  soft_reset_bank dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capability_mask_2(capability_mask_2),
    .analog_cmp_2_reset(a2), .analog_cmp_1_reset(a1), .analog_cmp_0_reset(a0),
    .gp_counter_3_reset(g3), .gp_counter_2_reset(g2), .gp_counter_1_reset(g1),
    .gp_counter_0_reset(g0), .two_wire_unit_0_reset(tw), .sync_serial_1_reset(s1),
    .sync_serial_0_reset(s0), .async_serial_2_reset(u2), .async_serial_1_reset(u1),
    .async_serial_0_reset(u0));

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // One classic cycle; held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  task automatic write_read(input logic [31:0] dat, input logic [31:0] exp, input string msg);
    wb_cycle(1'b1, REG, 4'hf, dat);
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    check(rd, exp, msg);
    check(outs, exp, "reset lines");
  endtask : write_read

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    check(outs, 32'h0000_0000, "lines in reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  initial begin
    #500000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    do_reset();
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    check(rd, soft_reset_pkg::SOFT_RESET_RESET_VALUE, "reset value");
    write_read(32'hffff_ffff, IMPL, "all ones");
    // Each peripheral bit alone
    for (int i = 0; i < 13; i++) begin
      write_read(32'h1 << pos[i], 32'h1 << pos[i], "single bit");
    end
    write_read(32'h0000_0000, 32'h0000_0000, "release all");
    // Read-modify-write keeps unused positions as read
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    write_read(rd | 32'h0000_1000, 32'h0000_1000, "modify");
    wb_cycle(1'b1, REG, 4'h1, 32'hffff_ffff);
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    check(rd, 32'h0000_1037, "low lane only");
    capability_mask_2 <= 32'h0505_0505;
    write_read(32'hffff_ffff, IMPL & 32'h0505_0505, "masked write");
    capability_mask_2 <= 32'h0000_0000;
    repeat (2) @(posedge clk);
    check(outs, 32'h0000_0000, "mask removed");
    write_read(32'hffff_ffff, 32'h0000_0000, "no capability");
    capability_mask_2 <= 32'hffff_ffff;
    write_read(32'h0000_0011, 32'h0000_0011, "before unmapped");
    wb_cycle(1'b1, 12'h048, 4'hf, 32'hffff_ffff);
    wb_cycle(1'b0, 12'h048, 4'hf, 32'h0000_0000);
    check(rd, soft_reset_pkg::UNMAPPED_READ_VALUE, "unmapped read");
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    check(rd, 32'h0000_0011, "unmapped write ignored");
    write_read(32'hffff_ffff, IMPL, "before second reset");
    do_reset();
    wb_cycle(1'b0, REG, 4'hf, 32'h0000_0000);
    check(rd, 32'h0000_0000, "cleared by reset");
    stop_test();
  end
endmodule : test_soft_reset_bank
